/* File: core/rtc_map.vh */
/*
 * register map, control and status field positions, reset values and
 * timing figures of the seconds counter / watchdog core.
 * assumes the including file runs on a 125 MHz system clock.
 */
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// register locations (pointer values)
`define RTC_ADDR_TOD0      4'h0
`define RTC_ADDR_TOD3      4'h3
`define RTC_ADDR_CD0       4'h4
`define RTC_ADDR_CD2       4'h6
`define RTC_ADDR_CTRL      4'h7
`define RTC_ADDR_STAT      4'h8
`define RTC_ADDR_CHG       4'h9
// pointer wraps to zero after this location during multibyte access
`define RTC_PTR_WRAP       4'h8
`define RTC_PTR_LAST       4'h9

// control register fields
`define RTC_CTL_OSC_DIS    7
`define RTC_CTL_EN         6
`define RTC_CTL_MODE       5
`define RTC_CTL_BACKUP_SQUARE_WAVE_ENABLE      4
`define RTC_CTL_STEER      3
`define RTC_CTL_RS_HI      2
`define RTC_CTL_RS_LO      1
`define RTC_CTL_AIE        0

// status register fields
`define RTC_STAT_OSF       7
`define RTC_STAT_ZERO      0

// reset values, charger key and refused-read value
`define RTC_CTL_RESET      8'h06
`define RTC_CHG_RESET      8'h00
`define RTC_CHG_KEY        4'ha
`define RTC_BLOCKED_READ   8'hff

// timing: system clock, pulse widths, oscillator division
`define RTC_SYS_CLK_KHZ    125000
`define RTC_PULSE_MS       250
`define RTC_OSC_START_MS   1000
`define RTC_PRESC_SEC_LAST 15'h7fff
`define RTC_PRESC_WD_LAST  3'h7

`endif

/* File: core/rtc_sync.v */
/*
 * two-flop synchroniser for a group of single-bit levels, one chain per bit.
 * assumes the inputs are asynchronous to clk and only the second flop is read.
 */
module rtc_sync #(
	parameter           W    = 3,
	parameter [W-1:0]   INIT = {W{1'b0}}
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst,
	// levels in and out
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	genvar i;

	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_q;  // first stage, read only by the second stage
			reg sync_q;  // second stage, safe to use

			// both stages take the reset constant; no port value under reset
			always @(posedge clk) begin
				if (rst) begin
					meta_q <= INIT[i];
					sync_q <= INIT[i];
				end else begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
				end
			end

			assign sync_out[i] = sync_q;
		end
	endgenerate

endmodule

/* File: core/rtc_core.v */
/*
 * seconds counter and watchdog/alarm countdown core with reset sequencing.
 * assumes a serial-bus front end on sys_clk that delivers start/stop
 * pulses and byte-wide pointer, write and read strobes; the oscillator,
 * supply comparator and reset pin arrive asynchronously.
 */
// What this block does
// - refuse register access while supply failed
// - access resumes only after reset pin high
// - pointer increments, wraps back to location zero
// - snapshot time on start, stop, pointer wrap
// - 32-bit seconds up counter, bytes zero-three
// - reads latch value into holding register
// - seconds byte write resets square-wave phase
// - countdown write loads counter and seed
// - countdown disabled acts as plain storage
// - all-zero countdown write disables counting
// - alarm mode: per second, flag, reload
// - alarm mode interrupt follows flag when enabled
// - watchdog mode counts 4096 steps per second
// - watchdog read or write reloads seed
// - watchdog zero sets flag and halts
// - steering 0: reset pulse, block, clear
// - steering 1: interrupt pulse when enabled
// - watchdog pulse cannot be cut short
// - write during pulse counts after pulse
// - power fail resets, tail plus startup if oscillator was stopped
// - pushbutton debounce, wait release, tail
`include "rtc_map.vh"

module rtc_core #(
	parameter [31:0] PULSE_CYCLES = `RTC_PULSE_MS * `RTC_SYS_CLK_KHZ,
	parameter [31:0] START_CYCLES = `RTC_OSC_START_MS * `RTC_SYS_CLK_KHZ
) (
	// clock and reset
	input  wire       sys_clk,
	input  wire       rst,
	// asynchronous inputs
	input  wire       osc_clk,
	input  wire       power_fail,
	input  wire       rst_pin_in,
	// register port from the serial front end
	input  wire       bus_start,
	input  wire       bus_stop,
	input  wire       ptr_load,
	input  wire [7:0] ptr_data,
	input  wire       wr_en,
	input  wire [7:0] wr_data,
	input  wire       rd_en,
	output reg  [7:0] rd_data_q,
	output reg        rd_valid_q,
	output wire       access_ok,
	// open-drain pins, enable high pulls low
	output wire       rst_pin_out,
	output reg        rst_pin_oe_q,
	output wire       int_pin_out,
	output reg        int_pin_oe_q,
	output wire       square_wave_out,
	output reg        sqw_oe_q,
	// charger selection decoded from its register
	output wire       charger_enable
);

	// reset sequencer states, one-hot
	localparam [6:0] S_IDLE = 7'b0000001;  // watching the pin
	localparam [6:0] S_PF   = 7'b0000010;  // supply failed
	localparam [6:0] S_PFT  = 7'b0000100;  // post-recovery hold
	localparam [6:0] S_PBD  = 7'b0001000;  // pushbutton debounce
	localparam [6:0] S_PBW  = 7'b0010000;  // waiting for button release
	localparam [6:0] S_PBT  = 7'b0100000;  // post-release hold
	localparam [6:0] S_WDP  = 7'b1000000;  // watchdog reset pulse

	// synchronised inputs
	wire [2:0]  sync_out;
	wire        osc_s     = sync_out[0];
	wire        pf_s      = sync_out[1];
	wire        pin_s     = sync_out[2];

	reg         osc_prev_q;        // oscillator level one cycle ago
	reg         pin_prev_q;        // reset pin level one cycle ago
	reg  [14:0] presc_q;           // oscillator edge prescaler
	reg  [31:0] tod_q;             // live seconds counter
	reg  [31:0] snap_q;            // time snapshot served to reads
	reg  [23:0] cnt_q;             // live countdown
	reg  [23:0] seed_q;            // reload value
	reg         halted_q;          // watchdog stopped at zero
	reg         zero_lock_q;       // countdown written all zero
	reg  [7:0]  ctl_q;             // control register
	reg         osf_q;             // oscillator stopped flag
	reg         af_q;              // countdown zero flag
	reg  [7:0]  chg_q;             // charger setup storage
	reg  [3:0]  ptr_q;             // register pointer
	reg  [6:0]  st_q;              // reset sequencer state
	reg  [31:0] rt_q;              // reset sequencer timer
	reg         osc_was_off_q;     // oscillator stopped during the fail
	reg         int_busy_q;        // interrupt pulse running
	reg  [31:0] it_q;              // interrupt pulse timer

	// input synchronisers: oscillator, supply comparator, reset pin
	// the pin starts low: our own reset drive holds it there, so a high
	// start value would show a false button press right after reset
	rtc_sync #(
		.W    (3),
		.INIT (3'b000)
	) u_sync (
		.clk      (sys_clk),
		.rst      (rst),
		.async_in ({rst_pin_in, power_fail, osc_clk}),
		.sync_out (sync_out)
	);

	// decoded control fields
	wire osc_dis  = ctl_q[`RTC_CTL_OSC_DIS];
	wire cd_en    = ctl_q[`RTC_CTL_EN];
	wire wd_mode  = ctl_q[`RTC_CTL_MODE];
	wire steer    = ctl_q[`RTC_CTL_STEER];
	wire alarm_irq_enable      = ctl_q[`RTC_CTL_AIE];

	// oscillator held only when on backup with the stop bit set
	wire osc_run  = ~(pf_s & osc_dis);
	wire osc_rise = osc_s & ~osc_prev_q & osc_run;
	wire sec_tick = osc_rise & (presc_q == `RTC_PRESC_SEC_LAST);
	wire wd_tick  = osc_rise & (presc_q[2:0] == `RTC_PRESC_WD_LAST);

	// bus access gating
	wire idle     = st_q[0];
	assign access_ok = idle & ~pf_s & pin_s;
	wire do_wr    = wr_en & access_ok;
	wire do_rd    = rd_en & access_ok;
	wire do_ptr   = ptr_load & access_ok;
	wire in_tod   = (ptr_q <= `RTC_ADDR_TOD3);
	wire in_cd    = (ptr_q >= `RTC_ADDR_CD0) & (ptr_q <= `RTC_ADDR_CD2);
	wire [1:0] byte_sel = ptr_q[1:0];
	wire wr_tod   = do_wr & in_tod;
	wire wr_cd    = do_wr & in_cd;
	wire rd_cd    = do_rd & in_cd;
	wire wr_ctl   = do_wr & (ptr_q == `RTC_ADDR_CTRL);
	wire wr_stat  = do_wr & (ptr_q == `RTC_ADDR_STAT);

	// next pointer: wrap to zero past the status location or the last one
	wire [3:0] ptr_next = ((ptr_q == `RTC_PTR_WRAP) | (ptr_q == `RTC_PTR_LAST)) ?
	                      `RTC_ADDR_TOD0 : ptr_q + 4'h1;
	wire ptr_wrap = (do_wr | do_rd) & (ptr_next == `RTC_ADDR_TOD0);

	// countdown state after a byte write, used for the all-zero check
	reg  [23:0] seed_wr;
	always @* begin
		seed_wr = seed_q;
		case (byte_sel)
			2'b00:   seed_wr[7:0]   = wr_data;
			2'b01:   seed_wr[15:8]  = wr_data;
			2'b10:   seed_wr[23:16] = wr_data;
			default: seed_wr        = seed_q;
		endcase
	end

	// countdown decisions
	wire pulse_busy = st_q[6] | int_busy_q;
	wire cd_active  = cd_en & ~zero_lock_q;
	wire step       = cd_active & ~pulse_busy & ~halted_q &
	                  (wd_mode ? wd_tick : sec_tick);
	wire at_zero    = (cnt_q <= 24'h000001);
	wire alarm_hit  = step & ~wd_mode & at_zero;
	wire wd_hit     = step & wd_mode & at_zero;
	wire wd_rst_req = wd_hit & ~steer;
	wire wd_int_req = wd_hit & steer & alarm_irq_enable;
	wire rt_done    = (rt_q == 32'h0);
	wire it_done    = int_busy_q & (it_q == 32'h0);
	wire wd_end     = (st_q[6] & rt_done) | it_done;

	// edge trackers for oscillator and reset pin
	always @(posedge sys_clk) begin
		if (rst) begin
			osc_prev_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			osc_prev_q <= osc_s;
			pin_prev_q <= pin_s;
		end
	end

	// prescaler; a seconds write restarts the phase of the 1 Hz output
	always @(posedge sys_clk) begin
		if (rst) begin
			presc_q <= 15'h0000;
		end else if (wr_tod) begin
			presc_q <= 15'h0000;
		end else if (osc_rise) begin
			presc_q <= presc_q + 15'h0001;
		end
	end

	// seconds counter and its snapshot
	always @(posedge sys_clk) begin
		if (rst) begin
			tod_q  <= 32'h00000000;
			snap_q <= 32'h00000000;
		end else begin
			if (wr_tod) begin
				// software byte wins over the tick in the same cycle
				tod_q[byte_sel*8 +: 8] <= wr_data;
			end else if (sec_tick) begin
				tod_q <= tod_q + 32'h00000001;
			end
			if (bus_start | bus_stop | ptr_wrap) begin
				snap_q <= tod_q;
			end
		end
	end

	// countdown counter, seed, halt and zero lock
	always @(posedge sys_clk) begin
		if (rst) begin
			cnt_q       <= 24'h000000;
			seed_q      <= 24'h000000;
			halted_q    <= 1'b0;
			zero_lock_q <= 1'b1;
		end else begin
			if (wr_cd) begin
				// write loads both; during a pulse it waits, see pulse_busy
				seed_q   <= seed_wr;
				cnt_q    <= seed_wr;
				halted_q <= 1'b0;
			end else if (rd_cd & cd_active & wd_mode) begin
				// a read in watchdog mode is the kick
				cnt_q    <= seed_q;
				halted_q <= 1'b0;
			end else if (alarm_hit) begin
				cnt_q <= seed_q;
			end else if (wd_hit) begin
				cnt_q    <= 24'h000000;
				halted_q <= 1'b1;
			end else if (step) begin
				cnt_q <= cnt_q - 24'h000001;
			end
			// all-zero content locks; the host's enable toggle unlocks
			if (wr_cd & (seed_wr == 24'h000000)) begin
				zero_lock_q <= 1'b1;
			end else if (wr_ctl & wr_data[`RTC_CTL_EN] & ~cd_en &
			             (seed_q != 24'h000000)) begin
				zero_lock_q <= 1'b0;
			end
		end
	end

	// control, charger and status flags; hardware set beats any clear
	always @(posedge sys_clk) begin
		if (rst) begin
			ctl_q <= `RTC_CTL_RESET;
			chg_q <= `RTC_CHG_RESET;
			osf_q <= 1'b1;
			af_q  <= 1'b0;
		end else begin
			if (wr_ctl) begin
				ctl_q <= wr_data;
			end
			if (do_wr & (ptr_q == `RTC_ADDR_CHG)) begin
				chg_q <= wr_data;
			end
			if (~osc_run) begin
				osf_q <= 1'b1;
			end else if (wr_stat & ~wr_data[`RTC_STAT_OSF]) begin
				osf_q <= 1'b0;
			end
			if (alarm_hit | wd_hit) begin
				af_q <= 1'b1;
			end else if (wd_end) begin
				af_q <= 1'b0;
			end else if (wr_stat & ~wr_data[`RTC_STAT_ZERO]) begin
				af_q <= 1'b0;
			end
		end
	end

	// pointer and read holding register
	always @(posedge sys_clk) begin
		if (rst) begin
			ptr_q      <= `RTC_ADDR_TOD0;
			rd_data_q  <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_en;
			if (do_ptr) begin
				ptr_q <= ptr_data[3:0];
			end else if (do_wr | do_rd) begin
				ptr_q <= ptr_next;
			end
			if (rd_en & ~access_ok) begin
				rd_data_q <= `RTC_BLOCKED_READ;
			end else if (do_rd) begin
				// the value is held here while the live counters run on
				case (ptr_q)
					4'h0, 4'h1, 4'h2, 4'h3: rd_data_q <= snap_q[byte_sel*8 +: 8];
					4'h4, 4'h5, 4'h6:       rd_data_q <= cnt_q[byte_sel*8 +: 8];
					`RTC_ADDR_CTRL:         rd_data_q <= ctl_q;
					`RTC_ADDR_STAT:         rd_data_q <= {osf_q, 6'h00, af_q};
					`RTC_ADDR_CHG:          rd_data_q <= chg_q;
					default:                rd_data_q <= 8'h00;
				endcase
			end
		end
	end

	// reset sequencer: power fail, pushbutton, watchdog pulse
	always @(posedge sys_clk) begin
		if (rst) begin
			st_q          <= S_IDLE;
			rt_q          <= 32'h0;
			osc_was_off_q <= 1'b0;
		end else begin
			if (~rt_done) begin
				rt_q <= rt_q - 32'h1;
			end
			if (pf_s & osc_dis) begin
				osc_was_off_q <= 1'b1;
			end
			if (pf_s) begin
				st_q <= S_PF;
			end else begin
				case (st_q)
					S_IDLE: begin
						if (wd_rst_req) begin
							st_q <= S_WDP;
							rt_q <= PULSE_CYCLES - 32'h1;
						end else if (~pin_s & pin_prev_q) begin
							st_q <= S_PBD;
							rt_q <= PULSE_CYCLES - 32'h1;
						end
					end
					S_PF: begin
						// stopped oscillator needs its start-up time as well
						st_q          <= S_PFT;
						rt_q          <= PULSE_CYCLES - 32'h1 +
						                 (osc_was_off_q ? START_CYCLES : 32'h0);
						osc_was_off_q <= 1'b0;
					end
					S_PBD: begin
						if (rt_done) begin
							st_q <= S_PBW;
						end
					end
					S_PBW: begin
						// the pin reads low for two cycles after we let go
						if (pin_s & ~pin_prev_q) begin
							st_q <= S_PBT;
							rt_q <= PULSE_CYCLES - 32'h1;
						end
					end
					S_PFT, S_PBT, S_WDP: begin
						if (rt_done) begin
							st_q <= S_IDLE;
						end
					end
					default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	// interrupt pulse timer; software writes never shorten it
	always @(posedge sys_clk) begin
		if (rst) begin
			int_busy_q <= 1'b0;
			it_q       <= 32'h0;
		end else if (wd_int_req & ~int_busy_q) begin
			int_busy_q <= 1'b1;
			it_q       <= PULSE_CYCLES - 32'h1;
		end else if (it_done) begin
			int_busy_q <= 1'b0;
		end else if (int_busy_q) begin
			it_q <= it_q - 32'h1;
		end
	end

	// square-wave source picked by the rate bits
	reg sqw_lvl;
	always @* begin
		case (ctl_q[`RTC_CTL_RS_HI:`RTC_CTL_RS_LO])
			2'b00:   sqw_lvl = presc_q[14];
			2'b01:   sqw_lvl = presc_q[2];
			2'b10:   sqw_lvl = presc_q[1];
			default: sqw_lvl = osc_s;
		endcase
	end

	// registered pin enables; the open-drain drivers always pull low
	always @(posedge sys_clk) begin
		if (rst) begin
			rst_pin_oe_q <= 1'b1;
			int_pin_oe_q <= 1'b0;
			sqw_oe_q     <= 1'b0;
		end else begin
			rst_pin_oe_q <= pf_s | ~(st_q[0] | st_q[4]);
			int_pin_oe_q <= int_busy_q | (~wd_mode & alarm_irq_enable & af_q);
			sqw_oe_q     <= ~sqw_lvl & (~pf_s | ctl_q[`RTC_CTL_BACKUP_SQUARE_WAVE_ENABLE]);
		end
	end

	assign rst_pin_out     = 1'b0;
	assign int_pin_out     = 1'b0;
	assign square_wave_out = 1'b0;
	assign charger_enable  = (chg_q[7:4] == `RTC_CHG_KEY) &
	                         (chg_q[3] ^ chg_q[2]) & (chg_q[1:0] != 2'b00);

endmodule

/* File: verif/rtc_core_monitor.sv */
/*
 * port-level checks of the seconds counter / watchdog core.
 * assumes sys_clk rising edge, synchronous active-high rst, bound to rtc_core.
 */
module rtc_core_monitor #(
	parameter [31:0] PULSE_CYCLES = 32'd200
) (
	// clock and reset
	input wire       sys_clk,
	input wire       rst,
	// pins seen from outside
	input wire       power_fail,
	input wire       rst_pin_in,
	// register port
	input wire       rd_en,
	input wire [7:0] rd_data_q,
	input wire       rd_valid_q,
	input wire       access_ok,
	// pin drives
	input wire       rst_pin_oe_q,
	input wire       int_pin_oe_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	reg [31:0] low_run_q; // cycles the reset pin has been pulled low so far

	// length of the current reset drive; a core reset counts as a full pulse
	always @(posedge sys_clk) begin
		if (rst)
			low_run_q <= PULSE_CYCLES;
		else if (rst_pin_oe_q)
			low_run_q <= low_run_q + 32'd1;
		else
			low_run_q <= 32'd0;
	end

	a_read_answer: assert property (rd_en |=> rd_valid_q)
		else $error("read strobe not answered next cycle");
	a_valid_cause: assert property (rd_valid_q |-> $past(rd_en))
		else $error("read valid without a read strobe");
	a_refused_ff: assert property (rd_en && !access_ok |=> rd_data_q == 8'hff)
		else $error("refused read did not return ff");
	a_data_holds: assert property (!rd_en |=> $stable(rd_data_q))
		else $error("read data changed without a read");
	a_pf_blocks: assert property (power_fail [*5] |-> !access_ok)
		else $error("access open during power fail");
	a_pf_pulls_rst: assert property (power_fail [*6] |-> rst_pin_oe_q)
		else $error("reset pin not driven during power fail");
	a_pulse_len: assert property ($fell(rst_pin_oe_q) |-> low_run_q >= PULSE_CYCLES)
		else $error("reset pulse shorter than pulse length");
	a_pin_blocks: assert property (rst_pin_oe_q |-> !access_ok)
		else $error("access open while reset pin driven");
	a_release_wait: assert property (!rst_pin_in [*4] |-> !access_ok)
		else $error("access open while reset pin held low");
	a_button_seen: assert property ($fell(rst_pin_in) && !rst_pin_oe_q && access_ok
		|-> ##[1:6] rst_pin_oe_q)
		else $error("button press not debounced in time");

	c_refused: cover property (rd_en && !access_ok);
	c_int_pulse: cover property ($rose(int_pin_oe_q));
	c_button: cover property ($fell(rst_pin_in) && !rst_pin_oe_q);
endmodule

bind rtc_core rtc_core_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) i_mon (
	.sys_clk(sys_clk), .rst(rst), .power_fail(power_fail), .rst_pin_in(rst_pin_in),
	.rd_en(rd_en), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
	.access_ok(access_ok), .rst_pin_oe_q(rst_pin_oe_q), .int_pin_oe_q(int_pin_oe_q)
);

/* File: verif/rtc_far_end.sv */
/*
 * far side of the core: crystal oscillator and the reset pin wire with its
 * pull-up and pushbutton. assumes the core drives the pin low via its enable.
 */
module rtc_far_end (
	// pushbutton and the core's drive
	input  wire button_down,
	input  wire rst_pin_oe_q,
	// levels seen by the core
	output wire rst_pin_in,
	output reg  osc_clk
);
	timeunit 1ns;
	timeprecision 100ps;

	// free-running crystal, 64 ns period in simulation
	initial osc_clk = 1'b0;
	always #32 osc_clk = ~osc_clk;

	// pull-up wins unless the core or the button pulls low
	assign rst_pin_in = !(rst_pin_oe_q || button_down);
endmodule

/* File: verif/rtc_core_test.sv */
/*
 * self-checking bench of the core through its byte register port.
 * assumes shortened pulse (200) and startup (100) counts.
 */
module rtc_core_test;
	timeunit 1ns;
	timeprecision 100ps;

	reg        sys_clk, rst, power_fail, button_down;   // clock, reset, pins
	reg        bus_start, bus_stop, ptr_load, wr_en, rd_en; // bus strobes
	reg  [7:0] ptr_data, wr_data;                     // bus bytes
	wire [7:0] rd_data_q;                             // read byte
	wire       rd_valid_q, access_ok, rst_pin_oe_q;   // port answers
	wire       int_pin_oe_q, osc_clk, rst_pin_in;     // pin levels
	wire       sqw_oe_q, charger_enable;              // square-wave drive, charger decode
	integer    miscompares, comparisons, cyc, n, i;   // bookkeeping

	rtc_core #(.PULSE_CYCLES(32'd200), .START_CYCLES(32'd100)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .osc_clk(osc_clk), .power_fail(power_fail),
		.rst_pin_in(rst_pin_in), .bus_start(bus_start), .bus_stop(bus_stop),
		.ptr_load(ptr_load), .ptr_data(ptr_data), .wr_en(wr_en), .wr_data(wr_data),
		.rd_en(rd_en), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.access_ok(access_ok), .rst_pin_out(), .rst_pin_oe_q(rst_pin_oe_q),
		.int_pin_out(), .int_pin_oe_q(int_pin_oe_q), .square_wave_out(),
		.sqw_oe_q(sqw_oe_q), .charger_enable(charger_enable)
	);
	rtc_far_end i_far (.button_down(button_down), .rst_pin_oe_q(rst_pin_oe_q),
		.rst_pin_in(rst_pin_in), .osc_clk(osc_clk));

	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	task report_and_stop;
		$display("comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hang guard: whole run needs well under this
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			miscompares = miscompares + 1;
			report_and_stop;
		end
	end

	task chk(input [7:0] seen, input [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// each strobe lasts one cycle and is followed by an idle cycle
	task setp(input [7:0] a);
		@(negedge sys_clk) ptr_load = 1'b1;
		ptr_data = a;
		@(negedge sys_clk) ptr_load = 1'b0;
	endtask
	task wb(input [7:0] v);
		@(negedge sys_clk) wr_en = 1'b1;
		wr_data = v;
		@(negedge sys_clk) wr_en = 1'b0;
	endtask
	task rd_only;
		@(negedge sys_clk) rd_en = 1'b1;
		@(negedge sys_clk) rd_en = 1'b0;
	endtask
	task rb(input [7:0] exp);
		rd_only;
		chk({7'h00, rd_valid_q}, 8'h01);
		chk(rd_data_q, exp);
	endtask
	// sel 1 watches the interrupt drive, 0 the reset drive; bounded waits
	task wait_hi(input sel);
		n = 0;
		while ((sel ? int_pin_oe_q : rst_pin_oe_q) !== 1'b1 && n < 1000) begin
			@(negedge sys_clk);
			n = n + 1;
		end
		chk({7'h00, n < 1000}, 8'h01);
	endtask
	task width(input sel, input integer lo, input integer hi);
		wait_hi(sel);
		n = 0;
		while ((sel ? int_pin_oe_q : rst_pin_oe_q) === 1'b1 && n < 1000) begin
			@(negedge sys_clk);
			n = n + 1;
		end
		chk({7'h00, n >= lo && n <= hi}, 8'h01);
	endtask
	task wait_ok;
		n = 0;
		while (access_ok !== 1'b1 && n < 1000) begin
			@(negedge sys_clk);
			n = n + 1;
		end
		chk({7'h00, access_ok}, 8'h01);
	endtask

	initial begin
		{miscompares, comparisons, cyc} = 0;
		{rst, power_fail, button_down} = 3'b100;
		{bus_start, bus_stop, ptr_load, wr_en, rd_en} = 5'h00;
		{ptr_data, wr_data} = 16'h0000;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		wait_ok;
		// seconds bytes: reads serve the snapshot until a stop refreshes it
		setp(8'h00);
		for (i = 0; i < 4; i = i + 1)
			wb(8'h44 - 8'h11 * i[7:0]);
		setp(8'h00);
		rb(8'h00);
		@(negedge sys_clk) bus_stop = 1'b1;
		@(negedge sys_clk) bus_stop = 1'b0;
		setp(8'h00);
		for (i = 0; i < 4; i = i + 1)
			rb(8'h44 - 8'h11 * i[7:0]);
		$display("test seconds done");
		// reset values, then pointer wrap after 08 and 09
		@(negedge sys_clk) bus_start = 1'b1;
		@(negedge sys_clk) bus_start = 1'b0;
		setp(8'h07);
		rb(8'h06);
		rb(8'h80);
		rb(8'h44);
		setp(8'h09);
		rb(8'h00);
		rb(8'h44);
		setp(8'h09);
		wb(8'ha5);
		chk({7'h00, charger_enable}, 8'h01);
		$display("test map done");
		// countdown off: plain storage
		setp(8'h04);
		for (i = 0; i < 3; i = i + 1)
			wb(8'h56 - 8'h22 * i[7:0]);
		repeat (300) @(negedge sys_clk);
		setp(8'h04);
		for (i = 0; i < 3; i = i + 1)
			rb(8'h56 - 8'h22 * i[7:0]);
		$display("test storage done");
		// watchdog steered to interrupt; reads keep reloading it
		setp(8'h04);
		wb(8'h03);
		wb(8'h00);
		wb(8'h00);
		wb(8'h29);
		setp(8'h07);
		wb(8'h69);
		for (i = 0; i < 10; i = i + 1) begin
			setp(8'h04);
			rd_only;
			repeat (30) @(negedge sys_clk);
			chk({7'h00, int_pin_oe_q}, 8'h00);
		end
		wait_hi(1'b1);
		chk({7'h00, n >= 90 && n <= 170}, 8'h01);
		setp(8'h08);
		wb(8'h00);
		setp(8'h07);
		wb(8'h68);
		setp(8'h04);
		wb(8'h03);
		width(1'b1, 170, 200);
		repeat (60) @(negedge sys_clk);
		setp(8'h08);
		rb(8'h00);
		repeat (250) @(negedge sys_clk);
		chk({7'h00, int_pin_oe_q}, 8'h00);
		setp(8'h08);
		rb(8'h01);
		setp(8'h08);
		wb(8'h00);
		repeat (300) @(negedge sys_clk);
		setp(8'h08);
		rb(8'h00);
		$display("test watchdog irq done");
		// watchdog steered to reset pin
		setp(8'h07);
		wb(8'h60);
		setp(8'h04);
		wb(8'h03);
		wait_hi(1'b0);
		setp(8'h07);
		rb(8'hff);
		width(1'b0, 180, 200);
		wait_ok;
		setp(8'h08);
		rb(8'h00);
		// all-zero count stays idle even when enabled
		setp(8'h04);
		wb(8'h00);
		wb(8'h00);
		wb(8'h00);
		repeat (300) @(negedge sys_clk);
		chk({7'h00, rst_pin_oe_q}, 8'h00);
		setp(8'h08);
		rb(8'h00);
		setp(8'h07);
		wb(8'h00);
		$display("test watchdog reset done");
		// supply failure blocks access, then a tail after recovery
		power_fail = 1'b1;
		repeat (10) @(negedge sys_clk);
		setp(8'h07);
		wb(8'h55);
		rb(8'hff);
		power_fail = 1'b0;
		width(1'b0, 198, 210);
		chk({7'h00, access_ok}, 8'h00);
		wait_ok;
		setp(8'h07);
		rb(8'h00);
		// fast square wave: a seconds write restarts its phase from zero
		setp(8'h07);
		wb(8'h02);
		setp(8'h00);
		wb(8'h55);
		repeat (2) @(negedge sys_clk);
		chk({7'h00, sqw_oe_q}, 8'h01);
		repeat (40) @(negedge sys_clk);
		chk({7'h00, sqw_oe_q}, 8'h00);
		$display("test power fail done");
		// pushbutton: debounce pulse, wait for release, second pulse
		button_down = 1'b1;
		repeat (20) @(negedge sys_clk);
		chk({7'h00, rst_pin_oe_q}, 8'h01);
		repeat (400) @(negedge sys_clk);
		chk({7'h00, rst_pin_oe_q}, 8'h00);
		chk({7'h00, access_ok}, 8'h00);
		button_down = 1'b0;
		width(1'b0, 198, 202);
		wait_ok;
		$display("test pushbutton done");
		report_and_stop;
	end
endmodule
